// ===== inc/cc16_pkg.sv
`default_nettype none
package cc16_pkg;
  localparam int CW = 16;
  localparam int BW = 8;
  localparam int AW = 4;
  localparam int MW = 4;
  localparam int CSW = 3;
  localparam int WGW = 2;
  localparam int NF_DEPTH = 4;
  // Register addresses on the 8-bit I/O bus
  localparam logic [AW-1:0] A_CTRL_A = 4'h0;
  localparam logic [AW-1:0] A_CTRL_B = 4'h1;
  localparam logic [AW-1:0] A_CNT_L = 4'h2;
  localparam logic [AW-1:0] A_CNT_H = 4'h3;
  localparam logic [AW-1:0] A_CAP_L = 4'h4;
  localparam logic [AW-1:0] A_CAP_H = 4'h5;
  localparam logic [AW-1:0] A_IRQ_EN = 4'h6;
  localparam logic [AW-1:0] A_FLAGS = 4'h7;
  localparam logic [AW-1:0] A_CMP_CS = 4'h8;
  // Field positions
  localparam int WGML_LSB = 0;
  localparam int WGMH_LSB = 3;
  localparam int CS_LSB = 0;
  localparam int NF_BIT = 7;
  localparam int EDGE_BIT = 6;
  localparam int CAP_BIT = 5;
  localparam int OVF_BIT = 2;
  localparam int CMPSEL_BIT = 2;
  localparam logic [CSW-1:0] CS_STOP = 3'h0;
  localparam logic [CSW-1:0] CS_SYS = 3'h1;
  // Waveform modes handled by the counter
  localparam logic [MW-1:0] M_PC8 = 4'h1;
  localparam logic [MW-1:0] M_PC9 = 4'h2;
  localparam logic [MW-1:0] M_PC10 = 4'h3;
  localparam logic [MW-1:0] M_CTC_OCR = 4'h4;
  localparam logic [MW-1:0] M_FP8 = 4'h5;
  localparam logic [MW-1:0] M_FP9 = 4'h6;
  localparam logic [MW-1:0] M_FP10 = 4'h7;
  localparam logic [MW-1:0] M_PFC_ICR = 4'h8;
  localparam logic [MW-1:0] M_PC_ICR = 4'hA;
  localparam logic [MW-1:0] M_CTC_ICR = 4'hC;
  localparam logic [MW-1:0] M_FP_ICR = 4'hE;
  localparam logic [CW-1:0] BOTTOM = 16'h0000;
  localparam logic [CW-1:0] TOP_8 = 16'h00FF;
  localparam logic [CW-1:0] TOP_9 = 16'h01FF;
  localparam logic [CW-1:0] TOP_10 = 16'h03FF;
  localparam logic [CW-1:0] MAX = 16'hFFFF;
  localparam logic [CW-1:0] ONE = 16'h0001;

  function automatic logic icr_top(input logic [MW-1:0] m);
    return m == M_PFC_ICR || m == M_PC_ICR || m == M_CTC_ICR || m == M_FP_ICR;
  endfunction : icr_top

  function automatic logic dual(input logic [MW-1:0] m);
    return m == M_PC8 || m == M_PC9 || m == M_PC10 || m == M_PFC_ICR || m == M_PC_ICR;
  endfunction : dual

  function automatic logic [CW-1:0] top_of(input logic [MW-1:0] m, input logic [CW-1:0] icr);
    case (m)
      M_PC8, M_FP8: return TOP_8;
      M_PC9, M_FP9: return TOP_9;
      M_PC10, M_FP10: return TOP_10;
      default: return icr_top(m) ? icr : MAX;
    endcase
  endfunction : top_of
endpackage : cc16_pkg
`default_nettype wire

// ===== inc/cc16_link_if.sv
`default_nettype none
interface cc16_link_if;
  import cc16_pkg::*;
  logic tick;
  logic load;
  logic [CW-1:0] load_val;
  logic [MW-1:0] mode;
  logic [CW-1:0] icr;
  logic [CW-1:0] count;
  logic ovf;
  logic pin_raw;
  logic cmp_raw;
  logic cmp_sel;
  logic nf_en;
  logic rise;
  logic arm;
  logic evt;
  modport cnt_mp(input tick, load, load_val, mode, icr, output count, ovf);
  modport evt_mp(input pin_raw, cmp_raw, cmp_sel, nf_en, rise, arm, output evt);
  modport ctl_mp(output tick, load, load_val, mode, icr, pin_raw, cmp_raw, cmp_sel,
    nf_en, rise, arm, input count, ovf, evt);
endinterface : cc16_link_if
`default_nettype wire

// ===== rtl/cc16_counter.sv
`default_nettype none
module cc16_counter (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  cc16_link_if.cnt_mp lk
);
  import cc16_pkg::*;
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic down;
  } cc16_cnt_st_t;
  cc16_cnt_st_t st_ff;
  cc16_cnt_st_t nxt_st;
  logic [CW-1:0] top;
  logic nxt_ovf;

  always_comb begin
    nxt_st = st_ff;
    nxt_ovf = 1'b0;
    top = top_of(lk.mode, lk.icr);
    if (lk.load) begin
      nxt_st.cnt = lk.load_val;
    end else if (lk.tick) begin
      if (dual(lk.mode)) begin
        if (!st_ff.down) begin
          if (st_ff.cnt >= top) begin
            nxt_st.down = 1'b1;
            nxt_st.cnt = st_ff.cnt - ONE;
          end else begin
            nxt_st.cnt = st_ff.cnt + ONE;
          end
        end else if (st_ff.cnt == BOTTOM) begin
          nxt_st.down = 1'b0;
          nxt_st.cnt = st_ff.cnt + ONE;
          nxt_ovf = 1'b1;
        end else begin
          nxt_st.cnt = st_ff.cnt - ONE;
        end
      end else begin
        nxt_st.down = 1'b0;
        nxt_st.cnt = (st_ff.cnt == top) ? BOTTOM : st_ff.cnt + ONE;
        if (lk.mode == M_CTC_OCR || lk.mode == M_CTC_ICR || top == MAX) begin
          nxt_ovf = st_ff.cnt == MAX;
        end else begin
          nxt_ovf = st_ff.cnt == top;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lk.count = st_ff.cnt;
  assign lk.ovf = nxt_ovf;
endmodule : cc16_counter
`default_nettype wire

// ===== rtl/cc16_evt_filter.sv
`default_nettype none
module cc16_evt_filter (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  cc16_link_if.evt_mp lk
);
  import cc16_pkg::*;
  typedef struct packed {
    logic [2:0] sync;
    logic stable;
    logic [NF_DEPTH-2:0] hist;
    logic filt;
    logic prev;
  } cc16_evt_st_t;
  cc16_evt_st_t st_ff;
  cc16_evt_st_t nxt_st;
  logic raw;
  logic src;

  always_comb begin
    nxt_st = st_ff;
    raw = lk.cmp_sel ? lk.cmp_raw : lk.pin_raw;
    nxt_st.sync = {st_ff.sync[1:0], raw};
    if (st_ff.sync[1] == st_ff.sync[2]) begin
      nxt_st.stable = st_ff.sync[2];
    end
    nxt_st.hist = {st_ff.hist[NF_DEPTH-3:0], st_ff.stable};
    if (&{st_ff.hist, st_ff.stable} || ~|{st_ff.hist, st_ff.stable}) begin
      nxt_st.filt = st_ff.stable;
    end
    src = lk.nf_en ? st_ff.filt : st_ff.stable;
    nxt_st.prev = src;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Edge detector, gated off in modes where the capture register is the top
  assign lk.evt = lk.arm && (lk.rise ? src && !st_ff.prev : !src && st_ff.prev);

  AST_FILTER_AGREE: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    lk.nf_en && $changed(st_ff.filt) |-> $past(st_ff.hist) == {(NF_DEPTH-1){st_ff.filt}})
    else $error("filtered level changed without four agreeing samples");
endmodule : cc16_evt_filter
`default_nettype wire

// ===== rtl/cc16_capture_timer.sv
`default_nettype none
module cc16_capture_timer (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [cc16_pkg::AW-1:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [cc16_pkg::BW-1:0] i_io_wdata,
  output logic [cc16_pkg::BW-1:0] o_io_rdata,
  input wire logic i_prescaled_tick,
  input wire logic i_capture_pin,
  input wire logic i_comparator_output,
  input wire logic i_capture_irq_ack,
  input wire logic i_overflow_irq_ack,
  output logic o_capture_irq,
  output logic o_overflow_irq,
  output logic o_at_bottom,
  output logic o_at_top
);
  import cc16_pkg::*;

  typedef struct packed {
    logic [WGW-1:0] wgm_lo;
    logic [WGW-1:0] wgm_hi;
    logic [CSW-1:0] cs;
    logic nf_en;
    logic rise;
    logic cmp_sel;
    logic cap_ie;
    logic ovf_ie;
    logic cap_flag;
    logic ovf_flag;
    logic [BW-1:0] temp;
    logic [CW-1:0] cap;
    logic [BW-1:0] rdata;
  } cc16_top_st_t;

  cc16_top_st_t st_ff;
  cc16_top_st_t nxt_st;
  logic [MW-1:0] mode;
  logic [CW-1:0] count;
  logic [CW-1:0] top;
  logic [BW-1:0] cnt_hi;
  logic [BW-1:0] rmux;
  logic cap_wr;
  logic cap_clr;
  logic ovf_clr;

  cc16_link_if lk ();

  cc16_counter u_counter (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .lk(lk.cnt_mp)
  );

  cc16_evt_filter u_evt_filter (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .lk(lk.evt_mp)
  );

  assign mode = {st_ff.wgm_hi, st_ff.wgm_lo};
  assign count = lk.count;
  assign cnt_hi = count[CW-1:BW];
  assign top = top_of(mode, st_ff.cap);

  // Timer tick: every cycle, the external prescaler pulse, or nothing
  assign lk.tick = (st_ff.cs == CS_SYS) || (st_ff.cs != CS_STOP && i_prescaled_tick);
  assign lk.load = i_io_wr && i_io_addr == A_CNT_L;
  assign lk.load_val = {st_ff.temp, i_io_wdata};
  assign lk.mode = mode;
  assign lk.icr = st_ff.cap;
  assign lk.pin_raw = i_capture_pin;
  assign lk.cmp_raw = i_comparator_output;
  assign lk.cmp_sel = st_ff.cmp_sel;
  assign lk.nf_en = st_ff.nf_en;
  assign lk.rise = st_ff.rise;
  assign lk.arm = !icr_top(mode);

  assign cap_wr = i_io_wr && i_io_addr == A_CAP_L && icr_top(mode);
  assign cap_clr = i_io_wr && i_io_addr == A_FLAGS && i_io_wdata[CAP_BIT];
  assign ovf_clr = i_io_wr && i_io_addr == A_FLAGS && i_io_wdata[OVF_BIT];

  // Read data for the addressed location
  always_comb begin
    rmux = '0;
    case (i_io_addr)
      A_CTRL_A: begin
        rmux[WGML_LSB +: WGW] = st_ff.wgm_lo;
      end
      A_CTRL_B: begin
        rmux[NF_BIT] = st_ff.nf_en;
        rmux[EDGE_BIT] = st_ff.rise;
        rmux[WGMH_LSB +: WGW] = st_ff.wgm_hi;
        rmux[CS_LSB +: CSW] = st_ff.cs;
      end
      A_CNT_L: begin
        rmux = count[BW-1:0];
      end
      A_CAP_L: begin
        rmux = st_ff.cap[BW-1:0];
      end
      A_CNT_H, A_CAP_H: begin
        rmux = st_ff.temp;
      end
      A_IRQ_EN: begin
        rmux[CAP_BIT] = st_ff.cap_ie;
        rmux[OVF_BIT] = st_ff.ovf_ie;
      end
      A_FLAGS: begin
        rmux[CAP_BIT] = st_ff.cap_flag;
        rmux[OVF_BIT] = st_ff.ovf_flag;
      end
      A_CMP_CS: begin
        rmux[CMPSEL_BIT] = st_ff.cmp_sel;
      end
      default: begin
        rmux = '0;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    // Reads: low byte access latches the matching high byte into temp
    if (i_io_rd) begin
      nxt_st.rdata = rmux;
      if (i_io_addr == A_CNT_L) begin
        nxt_st.temp = cnt_hi;
      end else if (i_io_addr == A_CAP_L) begin
        nxt_st.temp = st_ff.cap[CW-1:BW];
      end
    end
    // Writes
    if (i_io_wr) begin
      case (i_io_addr)
        A_CTRL_A: begin
          nxt_st.wgm_lo = i_io_wdata[WGML_LSB +: WGW];
        end
        A_CTRL_B: begin
          nxt_st.nf_en = i_io_wdata[NF_BIT];
          nxt_st.rise = i_io_wdata[EDGE_BIT];
          nxt_st.wgm_hi = i_io_wdata[WGMH_LSB +: WGW];
          nxt_st.cs = i_io_wdata[CS_LSB +: CSW];
        end
        A_CNT_H, A_CAP_H: begin
          nxt_st.temp = i_io_wdata;
        end
        A_CAP_L: begin
          if (cap_wr) begin
            nxt_st.cap = {st_ff.temp, i_io_wdata};
          end
        end
        A_IRQ_EN: begin
          nxt_st.cap_ie = i_io_wdata[CAP_BIT];
          nxt_st.ovf_ie = i_io_wdata[OVF_BIT];
        end
        A_CMP_CS: begin
          nxt_st.cmp_sel = i_io_wdata[CMPSEL_BIT];
        end
        default: begin
        end
      endcase
    end
    // Flag clears by write-one or interrupt service
    if (cap_clr || (o_capture_irq && i_capture_irq_ack)) begin
      nxt_st.cap_flag = 1'b0;
    end
    if (ovf_clr || (o_overflow_irq && i_overflow_irq_ack)) begin
      nxt_st.ovf_flag = 1'b0;
    end
    // Hardware sets win over clears in the same cycle
    if (lk.evt && !cap_wr) begin
      nxt_st.cap = count;
      nxt_st.cap_flag = 1'b1;
    end
    if (lk.ovf) begin
      nxt_st.ovf_flag = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_io_rdata = st_ff.rdata;
  assign o_capture_irq = st_ff.cap_flag && st_ff.cap_ie;
  assign o_overflow_irq = st_ff.ovf_flag && st_ff.ovf_ie;
  assign o_at_bottom = count == BOTTOM;
  assign o_at_top = count == top;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_HALT: assert property (
    st_ff.cs == CS_STOP && !lk.load |=> $stable(count))
    else $error("counter moved while clock select is zero");

  AST_COUNT_STEP: assert property (
    lk.tick && !lk.load && !dual(mode) && count != top |=> count == $past(count) + ONE)
    else $error("counter did not increment on tick");

  AST_WRAP_AT_TOP: assert property (
    lk.tick && !lk.load && !dual(mode) && count == top |=> count == BOTTOM)
    else $error("counter did not clear at top");

  AST_LOAD_WINS: assert property (
    lk.load |=> count == $past(lk.load_val))
    else $error("counter write did not take priority");

  AST_LOW_READ_TEMP: assert property (
    i_io_rd && !i_io_wr && i_io_addr == A_CNT_L |=> st_ff.temp == $past(cnt_hi))
    else $error("low counter read did not latch high byte");

  AST_HIGH_READ: assert property (
    i_io_rd && (i_io_addr == A_CNT_H || i_io_addr == A_CAP_H) |=> o_io_rdata == $past(st_ff.temp))
    else $error("high byte read did not return temp");

  AST_CAPTURE: assert property (
    lk.evt && !cap_wr |=> st_ff.cap == $past(count) && st_ff.cap_flag)
    else $error("capture did not copy counter and set flag");

  AST_W1C: assert property (
    cap_clr && !lk.evt |=> !st_ff.cap_flag)
    else $error("write one did not clear capture flag");

  AST_SERVICE_CLR: assert property (
    o_capture_irq && i_capture_irq_ack && !lk.evt |=> !st_ff.cap_flag)
    else $error("serviced capture interrupt left flag set");

  AST_NO_CAP_ICR: assert property (
    icr_top(mode) |-> !lk.evt)
    else $error("capture fired in capture-top mode");

  AST_ICR_WR_GUARD: assert property (
    i_io_wr && i_io_addr == A_CAP_L && !icr_top(mode) && !lk.evt |=> $stable(st_ff.cap))
    else $error("capture register written outside capture-top mode");

  AST_OVF_FLAG: assert property (
    lk.ovf |=> st_ff.ovf_flag)
    else $error("overflow event did not set flag");

  AST_OVF_W1C: assert property (
    ovf_clr && !lk.ovf |=> !st_ff.ovf_flag)
    else $error("write one did not clear overflow flag");

  AST_OVF_SERVICE: assert property (
    o_overflow_irq && i_overflow_irq_ack && !lk.ovf |=> !st_ff.ovf_flag)
    else $error("serviced overflow interrupt left flag set");

  AST_W0_KEEPS: assert property (
    i_io_wr && i_io_addr == A_FLAGS && !i_io_wdata[CAP_BIT] && st_ff.cap_flag &&
    !(o_capture_irq && i_capture_irq_ack) |=> st_ff.cap_flag)
    else $error("writing zero cleared capture flag");

  AST_FLAG_KEEPS: assert property (
    st_ff.cap_flag && !cap_clr && !(o_capture_irq && i_capture_irq_ack) |=> st_ff.cap_flag)
    else $error("capture flag dropped without a clear");

  AST_HIGH_WRITE_TEMP: assert property (
    i_io_wr && i_io_addr == A_CNT_H |=> st_ff.temp == $past(i_io_wdata))
    else $error("high counter write did not update temp");

  AST_HIGH_WRITE_ONLY: assert property (
    i_io_wr && i_io_addr == A_CNT_H && !lk.tick |=> $stable(count))
    else $error("high counter write changed the counter");

  AST_LOW_WRITE_HIGH: assert property (
    lk.load |=> count[CW-1:BW] == $past(st_ff.temp))
    else $error("low counter write did not load high byte from temp");

  AST_HIGH_READ_KEEPS: assert property (
    i_io_rd && !i_io_wr && i_io_addr == A_CNT_H |=> $stable(st_ff.temp))
    else $error("high counter read changed temp");

  AST_CAP_LOW_READ: assert property (
    i_io_rd && !i_io_wr && i_io_addr == A_CAP_L |=> st_ff.temp == $past(st_ff.cap[CW-1:BW]))
    else $error("capture low read did not latch high byte");

  AST_CAP_HOLD: assert property (
    !lk.evt && !cap_wr |=> $stable(st_ff.cap))
    else $error("capture register changed without event or write");

  AST_ICR_WRITE: assert property (
    cap_wr |=> st_ff.cap == {$past(st_ff.temp), $past(i_io_wdata)})
    else $error("capture register write did not take temp and low byte");

  AST_STOP_NO_TICK: assert property (
    st_ff.cs == CS_STOP |-> !lk.tick && !lk.ovf)
    else $error("tick or overflow while clock select is zero");

  AST_CS_WRITE: assert property (
    i_io_wr && i_io_addr == A_CTRL_B |=> st_ff.cs == $past(i_io_wdata[CS_LSB +: CSW]))
    else $error("clock select write did not land");

  AST_MODE_LOW: assert property (
    i_io_wr && i_io_addr == A_CTRL_A |=> mode[WGW-1:0] == $past(i_io_wdata[WGML_LSB +: WGW]))
    else $error("low mode bits write did not land");

  AST_CMP_SEL: assert property (
    i_io_wr && i_io_addr == A_CMP_CS |=> st_ff.cmp_sel == $past(i_io_wdata[CMPSEL_BIT]))
    else $error("comparator select write did not land");

  AST_MAX_OVF: assert property (
    lk.tick && !lk.load && !dual(mode) && count == MAX && top == MAX |-> lk.ovf)
    else $error("no overflow when leaving the maximum");

  AST_FAST_TOP_OVF: assert property (
    lk.tick && !lk.load && (mode == M_FP8 || mode == M_FP9 || mode == M_FP10) &&
    count == top |-> lk.ovf)
    else $error("no overflow at fixed top");

  COV_CAPTURE: cover property (lk.evt ##1 st_ff.cap_flag);
  COV_FILTERED: cover property (st_ff.nf_en && lk.evt);
  COV_OVF: cover property (lk.ovf ##1 o_overflow_irq);
  COV_LOAD_TICK: cover property (lk.load && lk.tick);
  COV_SERVICE: cover property (o_capture_irq && i_capture_irq_ack);
endmodule : cc16_capture_timer
`default_nettype wire

// ===== testbench/cc16_far_model.sv
`default_nettype none
module cc16_far_model (
  input wire logic i_core_clk,
  output logic o_tick,
  output logic o_pin,
  output logic o_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_tick = 1'b0;
    o_pin = 1'b0;
    o_cmp = 1'b0;
  end
  // Pad level, driven directly by this bench model
  task automatic pin(input logic v);
    @(posedge i_core_clk);
    #1 o_pin = v;
  endtask : pin
  // Comparator level
  task automatic cmp(input logic v);
    @(posedge i_core_clk);
    #1 o_cmp = v;
  endtask : cmp
  // Exact number of one-cycle prescaler ticks; top never moves meanwhile
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      #1 o_tick = !o_tick;
      @(posedge i_core_clk);
      #1 o_tick = !o_tick;
    end
  endtask : ticks
endmodule : cc16_far_model
`default_nettype wire

// ===== testbench/counter16_input_capture_bench.sv
`default_nettype none
module counter16_input_capture_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cc16_pkg::*;
  logic clk, rst_n, wr, rd, tick, pin, cmp, cack, oack, cirq, oirq, bot, top;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, q;
  logic [15:0] v16, ev, lf;
  logic [3:0] m;
  int miscompares, comparisons, lat0, n;

  cc16_capture_timer DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_io_addr(addr),
    .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata),
    .i_prescaled_tick(tick), .i_capture_pin(pin), .i_comparator_output(cmp),
    .i_capture_irq_ack(cack), .i_overflow_irq_ack(oack), .o_capture_irq(cirq),
    .o_overflow_irq(oirq), .o_at_bottom(bot), .o_at_top(top));
  cc16_far_model FAR (.i_core_clk(clk), .o_tick(tick), .o_pin(pin), .o_cmp(cmp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Count k ticks from c; bit 16 is set when a tick leaves the top
  function automatic logic [16:0] run(input logic [3:0] md, input logic [15:0] c, input int k);
    logic o;
    logic [15:0] t;
    o = 1'b0;
    t = (md == M_FP8) ? TOP_8 : MAX;
    repeat (k) begin
      o = o | (c == t);
      c = (c == t) ? BOTTOM : c + ONE;
    end
    return {o, c};
  endfunction : run

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic w1, input logic [3:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = w1;
    rd = !w1;
    @(posedge clk);
    #1 q = rdata;
    wr = 1'b0;
    rd = 1'b0;
    @(posedge clk);
    #1;
  endtask : bus

  task automatic w(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : w

  task automatic r(input logic [3:0] a);
    bus(1'b0, a, 8'h00);
  endtask : r

  task automatic rd16(input logic [3:0] lo);
    r(lo);
    v16[7:0] = q;
    r(lo + 4'h1);
    v16[15:8] = q;
  endtask : rd16

  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    w(lo + 4'h1, v[15:8]);
    w(lo, v[7:0]);
  endtask : wr16

  task automatic waitc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : waitc

  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #100us;
    miscompares++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
    cack = 1'b0;
    oack = 1'b0;
    lf = 16'h0028;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    chk(bot, 1'b1);
    rd16(A_CNT_L);
    chk(v16, 16'h0000);
    rd16(A_CAP_L);
    chk(v16, 16'h0000);
    r(A_FLAGS);
    chk(q, 8'h00);
    $display("test reset done");

    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      wr16(A_CNT_L, lf);
      waitc(5);
      rd16(A_CNT_L);
      chk(v16, lf);
    end
    $display("test counter access done");

    w(A_IRQ_EN, 8'h24);
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 4'h0 : M_FP8;
      ev = (i == 0) ? 16'hFFFE : (i == 1) ? 16'h00FE : 16'h0010;
      w(A_FLAGS, 8'h24);
      w(A_CTRL_A, {6'h00, m[1:0]});
      w(A_CTRL_B, {3'h0, m[3:2], 3'h2});
      wr16(A_CNT_L, ev);
      FAR.ticks(3 + i);
      w(A_CTRL_B, {3'h0, m[3:2], 3'h0});
      rd16(A_CNT_L);
      chk(v16, run(m, ev, 3 + i));
      chk(oirq, run(m, ev, 3 + i) >> 16);
      oack = oirq;
      waitc(1);
      oack = 1'b0;
      chk(oirq, 1'b0);
    end
    w(A_CTRL_A, 8'h00);
    $display("test counting done");

    for (int i = 0; i < 4; i++) begin
      w(A_CTRL_B, {1'b0, !pin, 6'h00});
      w(A_FLAGS, 8'h20);
      lf = lfsr(lf);
      wr16(A_CNT_L, lf);
      FAR.pin(!pin);
      waitc(8);
      chk(cirq, 1'b1);
      rd16(A_CAP_L);
      chk(v16, lf);
    end
    w(A_FLAGS, 8'h00);
    r(A_FLAGS);
    chk(q, 8'h20);
    cack = cirq;
    waitc(1);
    cack = 1'b0;
    chk(cirq, 1'b0);
    w(A_CTRL_B, {1'b0, pin, 6'h00});
    wr16(A_CNT_L, 16'h5A5A);
    FAR.pin(!pin);
    waitc(8);
    rd16(A_CAP_L);
    chk(v16, lf);
    r(A_FLAGS);
    chk(q, 8'h00);
    $display("test capture done");

    w(A_CMP_CS, 8'h04);
    w(A_CTRL_B, 8'h40);
    waitc(8);
    w(A_FLAGS, 8'h20);
    FAR.pin(!pin);
    FAR.pin(!pin);
    waitc(8);
    chk(cirq, 1'b0);
    FAR.cmp(1'b1);
    waitc(8);
    chk(cirq, 1'b1);
    rd16(A_CAP_L);
    chk(v16, 16'h5A5A);
    w(A_CMP_CS, 8'h00);
    $display("test comparator done");

    for (int f = 0; f < 2; f++) begin
      w(A_CTRL_B, {f[0], 7'h40});
      FAR.pin(1'b0);
      waitc(10);
      w(A_FLAGS, 8'h20);
      FAR.pin(1'b1);
      n = 0;
      while (cirq !== 1'b1 && n < 50) begin
        waitc(1);
        n++;
      end
      if (f == 0) lat0 = n;
    end
    chk(n - lat0, 4);
    FAR.pin(1'b0);
    waitc(10);
    w(A_FLAGS, 8'h20);
    lf = lfsr(lf);
    FAR.pin(1'b1);
    waitc(lf[1:0] % 3);
    FAR.pin(1'b0);
    waitc(15);
    chk(cirq, 1'b0);
    $display("test filter done");

    w(A_CTRL_B, 8'h40);
    wr16(A_CAP_L, 16'h1234);
    rd16(A_CAP_L);
    chk(v16, 16'h5A5A);
    w(A_CTRL_B, 8'h58);
    wr16(A_CAP_L, 16'hC3E1);
    w(A_FLAGS, 8'h20);
    FAR.pin(1'b1);
    waitc(8);
    rd16(A_CAP_L);
    chk(v16, 16'hC3E1);
    chk(cirq, 1'b0);
    w(A_CNT_H, 8'hA5);
    r(A_CAP_L);
    w(A_CNT_L, 8'h11);
    rd16(A_CNT_L);
    chk(v16, 16'hC311);
    wr16(A_CNT_L, 16'hC3E1);
    chk(top, 1'b1);
    chk(bot, 1'b0);
    $display("test capture top done");
    summarize();
  end
endmodule : counter16_input_capture_bench
`default_nettype wire
